// ==== src/csx_pkg.sv ====
package csx_pkg;

    localparam logic [31:0] VEC_RESET_ADDR = 32'h0000_0004;
    localparam logic [31:0] PSR_RESET = 32'h0000_0000;
    localparam logic [31:0] IP_RESET = 32'h0000_0000;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [3:0] GE_RESET = 4'h0;
    localparam logic [8:0] EXCNUM_RESET = 9'h000;
    localparam logic [7:0] COND_RESET = 8'h00;
    localparam logic MASK_RESET = 1'b0;

    // field positions in the combined status word
    localparam int FLAG_N_POS = 31;
    localparam int FLAG_Z_POS = 30;
    localparam int FLAG_C_POS = 29;
    localparam int FLAG_V_POS = 28;
    localparam int FLAG_Q_POS = 27;
    localparam int FLAGS_LSB = 27;
    localparam int COND_LO_MSB = 26;
    localparam int COND_LO_LSB = 25;
    localparam int TBIT_POS = 24;
    localparam int GE_MSB = 19;
    localparam int GE_LSB = 16;
    localparam int COND_HI_MSB = 15;
    localparam int COND_HI_LSB = 10;
    localparam int RESUME_MSB = 15;
    localparam int RESUME_LSB = 12;
    localparam int EXCNUM_MSB = 8;
    localparam int MASK_BIT_POS = 0;

    // active exception id encoding
    localparam logic [8:0] EXC_THREAD = 9'h000;
    localparam logic [8:0] EXC_NMI = 9'h002;
    localparam logic [8:0] EXC_HARD_FAULT = 9'h003;
    localparam logic [8:0] EXC_MEM_FAULT = 9'h004;
    localparam logic [8:0] EXC_BUS_FAULT = 9'h005;
    localparam logic [8:0] EXC_USAGE_FAULT = 9'h006;
    localparam logic [8:0] EXC_SVCALL = 9'h00B;
    localparam logic [8:0] EXC_PENDSV = 9'h00E;
    localparam logic [8:0] EXC_TICK = 9'h00F;
    localparam logic [8:0] EXC_IRQ_FIRST = 9'h010;
    localparam logic [8:0] EXC_IRQ_LAST = 9'h038;

    typedef enum logic [3:0] {
        SEL_STATUS,
        SEL_FLAG,
        SEL_NUMBER,
        SEL_EXEC,
        SEL_NUMBER_EXEC,
        SEL_NUMBER_FLAG,
        SEL_FLAG_EXEC,
        SEL_CFG_MASK,
        SEL_NMI_MASK
    } csx_sel_e;

    typedef enum logic {
        FSM_FETCH_VECTOR,
        FSM_RUN
    } csx_fsm_e;

    // flag results of the execute stage, {n,z,c,v} in nzcv
    typedef struct packed {
        logic flag_valid;
        logic [3:0] nzcv;
        logic ge_valid;
        logic [3:0] ge;
        logic saturated;
    } csx_alu_s;

    typedef struct packed {
        csx_fsm_e fsm;
        logic [31:0] ip;
        logic [4:0] flags;
        logic [3:0] ge;
        logic [8:0] excnum;
        logic [7:0] cond;
        logic tbit;
        logic resume_mode;
        logic cfg_mask;
        logic nmi_mask;
        logic [31:0] rdata;
    } csx_state_s;

endpackage : csx_pkg

// ==== src/csx_core_status.sv ====
`timescale 1ns/10ps
// Summary of operation
// - after reset fetch vector word at address four, load instruction pointer from it
// - vector bit zero goes to instruction-set state bit; software keeps it one
// - status word holds flag, number and exec views, separately or combined
// - writes through a view containing exception number leave those bits unchanged
// - exec-state bits read zero through every view and ignore writes
// - flags negative, zero, carry, overflow, saturation sit in bits 31 to 27
// - negative flag set for negative or less-than results, else cleared
// - zero flag set when result is zero, else cleared
// - carry set on add carry or subtract without borrow, else cleared
// - overflow flag set when operation overflows, else cleared
// - saturation flag sticky: set by saturate instructions, cleared only by software or return restore
// - four greater-equal flags live in bits 19 to 16
// - exception number field encodes thread, system exceptions and interrupt lines
// - interrupted multi-register transfer saves next operand index in bits 15:12
// - during resume-operand state bits 26:25 and 11:10 stay zero
// - conditional block covers up to four following conditional instructions
// - state bit cleared only by exchange branch, pop, return restore or vector
// - executing with state bit zero raises a fault
// - configurable mask set blocks all configurable-priority exceptions
// - fault mask set blocks every exception except non-maskable interrupt
// - masks change through status writes and mask-change instruction
// - fault mask cleared on return from any handler except non-maskable one
// - masks and exception number view are privileged; number view read-only
module csx_core_status (
    input wire logic CLK,
    input wire logic RST,
    output logic VEC_REQ,
    output logic [31:0] VEC_ADDR,
    input wire logic VEC_VALID,
    input wire logic [31:0] VEC_DATA,
    output logic [31:0] INSTR_PTR,
    output logic CORE_READY,
    input wire logic BRX_VALID,
    input wire logic [31:0] BRX_TARGET,
    input wire logic SR_VALID,
    input wire logic SR_WRITE,
    input wire csx_pkg::csx_sel_e SR_SEL,
    input wire logic SR_PRIV,
    input wire logic [31:0] SR_WDATA,
    output logic [31:0] SR_RDATA,
    input wire logic MC_VALID,
    input wire logic MC_NMI_MASK,
    input wire logic MC_DISABLE,
    input wire csx_pkg::csx_alu_s ALU,
    input wire logic COND_LOAD,
    input wire logic [7:0] COND_VALUE,
    input wire logic COND_ADVANCE,
    input wire logic XFER_SUSPEND,
    input wire logic [3:0] XFER_NEXT_IDX,
    input wire logic XFER_DONE,
    input wire logic EXC_ENTRY,
    input wire logic [8:0] EXC_NUM,
    input wire logic EXC_VEC_T,
    input wire logic EXC_RETURN,
    input wire logic [31:0] EXC_RET_PSR,
    output logic [31:0] STACKED_PSR,
    input wire logic [8:0] EXC_REQ_NUM,
    input wire logic EXC_REQ_CFG,
    output logic EXC_ALLOW,
    input wire logic EXEC_ATTEMPT,
    output logic T_FAULT,
    output logic COND_ACTIVE,
    output logic [3:0] COND_CODE,
    output logic RESUME_VALID,
    output logic [3:0] RESUME_IDX
);

    csx_pkg::csx_state_s st_r;
    csx_pkg::csx_state_s st_nxt;

    logic has_flag;
    logic has_number;
    logic running;

    function automatic logic [31:0] compose(input csx_pkg::csx_state_s s);
        logic [31:0] w;
        w = csx_pkg::PSR_RESET;
        w[csx_pkg::FLAG_N_POS:csx_pkg::FLAGS_LSB] = s.flags;
        w[csx_pkg::COND_LO_MSB:csx_pkg::COND_LO_LSB] = s.cond[1:0];
        w[csx_pkg::TBIT_POS] = s.tbit;
        w[csx_pkg::GE_MSB:csx_pkg::GE_LSB] = s.ge;
        w[csx_pkg::COND_HI_MSB:csx_pkg::COND_HI_LSB] = s.cond[7:2];
        w[csx_pkg::EXCNUM_MSB:0] = s.excnum;
        return w;
    endfunction : compose

    always_comb
    begin
        has_flag = (SR_SEL == csx_pkg::SEL_STATUS) || (SR_SEL == csx_pkg::SEL_FLAG) ||
            (SR_SEL == csx_pkg::SEL_NUMBER_FLAG) || (SR_SEL == csx_pkg::SEL_FLAG_EXEC);
        has_number = (SR_SEL == csx_pkg::SEL_STATUS) || (SR_SEL == csx_pkg::SEL_NUMBER) ||
            (SR_SEL == csx_pkg::SEL_NUMBER_EXEC) || (SR_SEL == csx_pkg::SEL_NUMBER_FLAG);
    end

    assign running = (st_r.fsm == csx_pkg::FSM_RUN);

    always_comb
    begin
        st_nxt = st_r;
        case (st_r.fsm)
            csx_pkg::FSM_FETCH_VECTOR:
            begin
                // nothing else is accepted until the vector word has arrived
                if (VEC_VALID)
                begin
                    st_nxt.ip = {VEC_DATA[31:1], 1'b0};
                    st_nxt.tbit = VEC_DATA[0];
                    st_nxt.fsm = csx_pkg::FSM_RUN;
                end
            end
            csx_pkg::FSM_RUN:
            begin
                if (EXC_RETURN)
                begin
                    // whole stacked word restored, number included
                    st_nxt.flags = EXC_RET_PSR[csx_pkg::FLAG_N_POS:csx_pkg::FLAGS_LSB];
                    st_nxt.ge = EXC_RET_PSR[csx_pkg::GE_MSB:csx_pkg::GE_LSB];
                    st_nxt.excnum = EXC_RET_PSR[csx_pkg::EXCNUM_MSB:0];
                    st_nxt.tbit = EXC_RET_PSR[csx_pkg::TBIT_POS];
                    st_nxt.cond = {EXC_RET_PSR[csx_pkg::COND_HI_MSB:csx_pkg::COND_HI_LSB],
                        EXC_RET_PSR[csx_pkg::COND_LO_MSB:csx_pkg::COND_LO_LSB]};
                    st_nxt.resume_mode = (EXC_RET_PSR[csx_pkg::COND_LO_MSB:csx_pkg::COND_LO_LSB]
                        == 2'b00) && (EXC_RET_PSR[11:10] == 2'b00) &&
                        (EXC_RET_PSR[csx_pkg::RESUME_MSB:csx_pkg::RESUME_LSB] != 4'h0);
                    if (st_r.excnum != csx_pkg::EXC_NMI)
                    begin
                        st_nxt.nmi_mask = 1'b0;
                    end
                end
                else if (EXC_ENTRY)
                begin
                    st_nxt.excnum = EXC_NUM;
                    st_nxt.tbit = EXC_VEC_T;
                    // a suspended transfer keeps its index across entry
                    if (!st_r.resume_mode)
                    begin
                        st_nxt.cond = csx_pkg::COND_RESET;
                    end
                end
                if (SR_VALID && SR_WRITE)
                begin
                    if (has_flag)
                    begin
                        st_nxt.flags = SR_WDATA[csx_pkg::FLAG_N_POS:csx_pkg::FLAGS_LSB];
                        st_nxt.ge = SR_WDATA[csx_pkg::GE_MSB:csx_pkg::GE_LSB];
                    end
                    // number and exec bits of the write are dropped
                    if (SR_PRIV && (SR_SEL == csx_pkg::SEL_CFG_MASK))
                    begin
                        st_nxt.cfg_mask = SR_WDATA[csx_pkg::MASK_BIT_POS];
                    end
                    if (SR_PRIV && (SR_SEL == csx_pkg::SEL_NMI_MASK))
                    begin
                        st_nxt.nmi_mask = SR_WDATA[csx_pkg::MASK_BIT_POS];
                    end
                end
                if (MC_VALID && SR_PRIV)
                begin
                    if (MC_NMI_MASK)
                    begin
                        st_nxt.nmi_mask = MC_DISABLE;
                    end
                    else
                    begin
                        st_nxt.cfg_mask = MC_DISABLE;
                    end
                end
                if (ALU.flag_valid)
                begin
                    st_nxt.flags[4] = ALU.nzcv[3];
                    st_nxt.flags[3] = ALU.nzcv[2];
                    st_nxt.flags[2] = ALU.nzcv[1];
                    st_nxt.flags[1] = ALU.nzcv[0];
                end
                if (ALU.ge_valid)
                begin
                    st_nxt.ge = ALU.ge;
                end
                // saturation set beats a software clear in the same cycle
                if (ALU.saturated)
                begin
                    st_nxt.flags[0] = 1'b1;
                end
                if (COND_LOAD)
                begin
                    st_nxt.cond = COND_VALUE;
                    st_nxt.resume_mode = 1'b0;
                end
                else if (COND_ADVANCE && !st_r.resume_mode)
                begin
                    // mask shifts left once per instruction, at most four
                    if (st_r.cond[2:0] == 3'b000)
                    begin
                        st_nxt.cond = csx_pkg::COND_RESET;
                    end
                    else
                    begin
                        st_nxt.cond[4:0] = {st_r.cond[3:0], 1'b0};
                    end
                end
                if (XFER_SUSPEND)
                begin
                    st_nxt.cond = {XFER_NEXT_IDX, 4'h0};
                    st_nxt.resume_mode = 1'b1;
                end
                else if (XFER_DONE && st_r.resume_mode)
                begin
                    st_nxt.cond = csx_pkg::COND_RESET;
                    st_nxt.resume_mode = 1'b0;
                end
                if (BRX_VALID)
                begin
                    st_nxt.ip = {BRX_TARGET[31:1], 1'b0};
                    st_nxt.tbit = BRX_TARGET[0];
                end
            end
            default:
            begin
                st_nxt.fsm = csx_pkg::FSM_FETCH_VECTOR;
            end
        endcase
        // read data registered, answers one cycle after the request
        st_nxt.rdata = 32'h0000_0000;
        if (running && SR_VALID && !SR_WRITE)
        begin
            if (has_flag)
            begin
                st_nxt.rdata[csx_pkg::FLAG_N_POS:csx_pkg::FLAGS_LSB] = st_r.flags;
                st_nxt.rdata[csx_pkg::GE_MSB:csx_pkg::GE_LSB] = st_r.ge;
            end
            if (has_number && SR_PRIV)
            begin
                st_nxt.rdata[csx_pkg::EXCNUM_MSB:0] = st_r.excnum;
            end
            if (SR_PRIV && (SR_SEL == csx_pkg::SEL_CFG_MASK))
            begin
                st_nxt.rdata[csx_pkg::MASK_BIT_POS] = st_r.cfg_mask;
            end
            if (SR_PRIV && (SR_SEL == csx_pkg::SEL_NMI_MASK))
            begin
                st_nxt.rdata[csx_pkg::MASK_BIT_POS] = st_r.nmi_mask;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_r.fsm <= csx_pkg::FSM_FETCH_VECTOR;
            st_r.ip <= csx_pkg::IP_RESET;
            st_r.flags <= csx_pkg::FLAGS_RESET;
            st_r.ge <= csx_pkg::GE_RESET;
            st_r.excnum <= csx_pkg::EXCNUM_RESET;
            st_r.cond <= csx_pkg::COND_RESET;
            st_r.tbit <= 1'b0;
            st_r.resume_mode <= 1'b0;
            st_r.cfg_mask <= csx_pkg::MASK_RESET;
            st_r.nmi_mask <= csx_pkg::MASK_RESET;
            st_r.rdata <= csx_pkg::PSR_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign VEC_REQ = !running;
    assign VEC_ADDR = csx_pkg::VEC_RESET_ADDR;
    assign INSTR_PTR = st_r.ip;
    assign CORE_READY = running;
    assign SR_RDATA = st_r.rdata;
    assign STACKED_PSR = compose(st_r);
    // nmi is held off only until the core runs; fixed-priority faults only by the fault mask
    assign EXC_ALLOW = running && !(st_r.nmi_mask && (EXC_REQ_NUM != csx_pkg::EXC_NMI)) &&
        !(st_r.cfg_mask && EXC_REQ_CFG);
    assign T_FAULT = running && EXEC_ATTEMPT && !st_r.tbit;
    assign COND_ACTIVE = !st_r.resume_mode && (st_r.cond[3:0] != 4'h0);
    assign COND_CODE = st_r.cond[7:4];
    assign RESUME_VALID = st_r.resume_mode;
    assign RESUME_IDX = st_r.cond[7:4];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    property p_vec_load;
        (!running && VEC_VALID) |=> (running && INSTR_PTR == {$past(VEC_DATA[31:1]), 1'b0});
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("reset vector not loaded");

    property p_vec_tbit;
        (!running && VEC_VALID) |=> (st_r.tbit == $past(VEC_DATA[0]));
    endproperty
    a_vec_tbit: assert property (p_vec_tbit) else $error("state bit not from vector");

    property p_number_kept;
        (running && SR_VALID && SR_WRITE && has_number && !EXC_ENTRY && !EXC_RETURN)
            |=> $stable(st_r.excnum);
    endproperty
    a_number_kept: assert property (p_number_kept) else $error("number written");

    property p_exec_reads_zero;
        (SR_VALID && !SR_WRITE) |=> (SR_RDATA[26:24] == 3'b000 && SR_RDATA[15:9] == 7'h00);
    endproperty
    a_exec_reads_zero: assert property (p_exec_reads_zero) else $error("exec bits read");

    property p_zero_flag;
        (running && ALU.flag_valid) |=> (st_r.flags[4:1] == $past(ALU.nzcv));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("flag not taken");

    property p_sat_sticky;
        (running && ALU.saturated) |=> st_r.flags[0] ##1
            (st_r.flags[0] || $past(SR_VALID && SR_WRITE) || $past(EXC_RETURN));
    endproperty
    a_sat_sticky: assert property (p_sat_sticky) else $error("sat flag lost");

    property p_resume_zero;
        st_r.resume_mode |-> (st_r.cond[3:0] == 4'h0 && STACKED_PSR[26:25] == 2'b00);
    endproperty
    a_resume_zero: assert property (p_resume_zero) else $error("resume bits dirty");

    property p_suspend_idx;
        (running && XFER_SUSPEND) |=> (RESUME_VALID && RESUME_IDX == $past(XFER_NEXT_IDX));
    endproperty
    a_suspend_idx: assert property (p_suspend_idx) else $error("index not saved");

    property p_tfault;
        (running && BRX_VALID && !BRX_TARGET[0]) ##1 EXEC_ATTEMPT |-> T_FAULT;
    endproperty
    a_tfault: assert property (p_tfault) else $error("no state fault");

    property p_cfg_block;
        (st_r.cfg_mask && EXC_REQ_CFG) |-> !EXC_ALLOW;
    endproperty
    a_cfg_block: assert property (p_cfg_block) else $error("cfg exception passed");

    property p_nmi_pass;
        (running && st_r.nmi_mask && !EXC_REQ_CFG && EXC_REQ_NUM == csx_pkg::EXC_NMI)
            |-> EXC_ALLOW;
    endproperty
    a_nmi_pass: assert property (p_nmi_pass) else $error("nmi blocked");

    property p_fault_clear;
        (running && EXC_RETURN && st_r.excnum != csx_pkg::EXC_NMI && !MC_VALID && !SR_VALID)
            |=> !st_r.nmi_mask;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault mask kept");

    property p_entry_number;
        (running && EXC_ENTRY && !EXC_RETURN) |=> (st_r.excnum == $past(EXC_NUM));
    endproperty
    a_entry_number: assert property (p_entry_number) else $error("number not set");

    c_boot: cover property (!running ##1 running);
    c_saturate: cover property (running && ALU.saturated ##1 st_r.flags[0]);
    c_suspend: cover property (XFER_SUSPEND ##1 EXC_ENTRY ##[1:20] EXC_RETURN);
    c_masked: cover property (st_r.nmi_mask && !EXC_ALLOW);

endmodule : csx_core_status

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic CLK = 1'b0, RST = 1'b1, VEC_REQ, CORE_READY, VEC_VALID = 1'b0, BRX_VALID = 1'b0;
    logic [31:0] VEC_ADDR, VEC_DATA = 32'h0000_0000, INSTR_PTR, BRX_TARGET = 32'h0000_0000;
    logic SR_VALID = 1'b0, SR_WRITE = 1'b0, SR_PRIV = 1'b0, MC_VALID = 1'b0;
    logic MC_NMI_MASK = 1'b0, MC_DISABLE = 1'b0, COND_LOAD = 1'b0, COND_ADVANCE = 1'b0;
    logic [31:0] SR_WDATA = 32'h0000_0000, SR_RDATA, EXC_RET_PSR = 32'h0000_0000, STACKED_PSR;
    csx_pkg::csx_sel_e SR_SEL = csx_pkg::SEL_STATUS;
    csx_pkg::csx_alu_s ALU = '0;
    logic [7:0] COND_VALUE = 8'h00;
    logic XFER_SUSPEND = 1'b0, XFER_DONE = 1'b0, EXC_ENTRY = 1'b0, EXC_VEC_T = 1'b0;
    logic [3:0] XFER_NEXT_IDX = 4'h0, COND_CODE, RESUME_IDX;
    logic [8:0] EXC_NUM = 9'h000, EXC_REQ_NUM = 9'h000;
    logic EXC_RETURN = 1'b0, EXC_REQ_CFG = 1'b0, EXC_ALLOW, EXEC_ATTEMPT = 1'b0, T_FAULT;
    logic COND_ACTIVE, RESUME_VALID;
    int fail_count = 0, n_tests = 0;
    logic [31:0] rd;

    always #20 CLK = ~CLK;

    csx_core_status dut_u (.CLK(CLK), .RST(RST), .VEC_REQ(VEC_REQ), .VEC_ADDR(VEC_ADDR),
        .VEC_VALID(VEC_VALID), .VEC_DATA(VEC_DATA), .INSTR_PTR(INSTR_PTR),
        .CORE_READY(CORE_READY), .BRX_VALID(BRX_VALID), .BRX_TARGET(BRX_TARGET),
        .SR_VALID(SR_VALID), .SR_WRITE(SR_WRITE), .SR_SEL(SR_SEL), .SR_PRIV(SR_PRIV),
        .SR_WDATA(SR_WDATA), .SR_RDATA(SR_RDATA), .MC_VALID(MC_VALID),
        .MC_NMI_MASK(MC_NMI_MASK), .MC_DISABLE(MC_DISABLE), .ALU(ALU), .COND_LOAD(COND_LOAD),
        .COND_VALUE(COND_VALUE), .COND_ADVANCE(COND_ADVANCE), .XFER_SUSPEND(XFER_SUSPEND),
        .XFER_NEXT_IDX(XFER_NEXT_IDX), .XFER_DONE(XFER_DONE), .EXC_ENTRY(EXC_ENTRY),
        .EXC_NUM(EXC_NUM), .EXC_VEC_T(EXC_VEC_T), .EXC_RETURN(EXC_RETURN),
        .EXC_RET_PSR(EXC_RET_PSR), .STACKED_PSR(STACKED_PSR), .EXC_REQ_NUM(EXC_REQ_NUM),
        .EXC_REQ_CFG(EXC_REQ_CFG), .EXC_ALLOW(EXC_ALLOW), .EXEC_ATTEMPT(EXEC_ATTEMPT),
        .T_FAULT(T_FAULT), .COND_ACTIVE(COND_ACTIVE), .COND_CODE(COND_CODE),
        .RESUME_VALID(RESUME_VALID), .RESUME_IDX(RESUME_IDX));

    task report_and_stop;
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task step;
        @(negedge CLK);
    endtask : step

    // one status move; read data stands one cycle, sampled at the next falling edge
    task sr_op(input logic wr, input csx_pkg::csx_sel_e sel, input logic priv,
               input logic [31:0] wd);
        SR_VALID = 1'b1; SR_WRITE = wr; SR_SEL = sel; SR_PRIV = priv; SR_WDATA = wd;
        step;
        SR_VALID = 1'b0;
        rd = SR_RDATA;
        step;
    endtask : sr_op

    task alu_pulse(input logic [3:0] nzcv, input logic [3:0] ge, input logic sat);
        ALU = '{flag_valid: 1'b1, nzcv: nzcv, ge_valid: 1'b1, ge: ge, saturated: sat};
        step;
        ALU = '0;
        step;
    endtask : alu_pulse

    task exc_enter(input logic [8:0] num);
        EXC_ENTRY = 1'b1; EXC_NUM = num; EXC_VEC_T = 1'b1;
        step;
        EXC_ENTRY = 1'b0;
        step;
    endtask : exc_enter

    task exc_ret(input logic [31:0] combined_status_word);
        EXC_RETURN = 1'b1; EXC_RET_PSR = combined_status_word;
        step;
        EXC_RETURN = 1'b0;
        step;
    endtask : exc_ret

    task t_vector;
        int i;
        check(VEC_ADDR, 32'h0000_0004);
        check({31'h0, VEC_REQ}, 32'h0000_0001);
        VEC_VALID = 1'b1; VEC_DATA = 32'h0000_0101;
        step;
        VEC_VALID = 1'b0;
        for (i = 0; i < 8 && CORE_READY !== 1'b1; i++)
            step;
        if (CORE_READY !== 1'b1)
        begin
            fail_count++;
            report_and_stop;
        end
        check(INSTR_PTR, 32'h0000_0100);
        check({31'h0, VEC_REQ}, 32'h0000_0000);
        check({31'h0, STACKED_PSR[24]}, 32'h0000_0001);
    endtask : t_vector

    task t_flags;
        int i;
        logic [31:0] exp_w;
        for (i = 0; i < 4; i++)
        begin
            alu_pulse(4'b1000 >> i, 4'h1 << i, 1'b0);
            sr_op(1'b0, csx_pkg::SEL_FLAG, 1'b0, 32'h0);
            exp_w = (32'h8000_0000 >> i) | (32'h0001_0000 << i);
            check(rd, exp_w);
        end
        alu_pulse(4'h0, 4'h0, 1'b1);
        alu_pulse(4'b0100, 4'h0, 1'b0);
        sr_op(1'b0, csx_pkg::SEL_FLAG, 1'b1, 32'h0);
        check(rd, 32'h4800_0000);
        sr_op(1'b1, csx_pkg::SEL_FLAG, 1'b1, 32'h0000_0000);
        sr_op(1'b0, csx_pkg::SEL_FLAG, 1'b1, 32'h0);
        check(rd, 32'h0000_0000);
    endtask : t_flags

    task t_views;
        logic [8:0] codes [12];
        int i;
        codes = '{csx_pkg::EXC_THREAD, csx_pkg::EXC_NMI, csx_pkg::EXC_HARD_FAULT,
                  csx_pkg::EXC_MEM_FAULT, csx_pkg::EXC_BUS_FAULT, csx_pkg::EXC_USAGE_FAULT,
                  csx_pkg::EXC_SVCALL, csx_pkg::EXC_PENDSV, csx_pkg::EXC_TICK,
                  csx_pkg::EXC_IRQ_LAST, 9'h02C, csx_pkg::EXC_IRQ_FIRST};
        for (i = 0; i < 12; i++)
        begin
            exc_enter(codes[i]);
            sr_op(1'b0, csx_pkg::SEL_NUMBER, 1'b1, 32'h0);
            check(rd, {23'h0, codes[i]});
        end
        sr_op(1'b0, csx_pkg::SEL_NUMBER, 1'b0, 32'h0);
        check(rd, 32'h0000_0000);
        sr_op(1'b1, csx_pkg::SEL_STATUS, 1'b1, 32'hFFFF_FFFF);
        sr_op(1'b0, csx_pkg::SEL_STATUS, 1'b1, 32'h0);
        check(rd, 32'hF80F_0010);
        check({31'h0, STACKED_PSR[24]}, 32'h0000_0001);
        sr_op(1'b0, csx_pkg::SEL_EXEC, 1'b1, 32'h0);
        check(rd, 32'h0000_0000);
        sr_op(1'b1, csx_pkg::SEL_NUMBER_FLAG, 1'b1, 32'h0000_0000);
        sr_op(1'b0, csx_pkg::SEL_NUMBER_EXEC, 1'b1, 32'h0);
        check(rd, 32'h0000_0010);
        sr_op(1'b0, csx_pkg::SEL_FLAG_EXEC, 1'b1, 32'h0);
        check(rd, 32'h0000_0000);
    endtask : t_views

    task t_masks;
        EXC_REQ_CFG = 1'b1; EXC_REQ_NUM = 9'h013;
        MC_VALID = 1'b1; MC_NMI_MASK = 1'b0; MC_DISABLE = 1'b1; SR_PRIV = 1'b0;
        step;
        check({31'h0, EXC_ALLOW}, 32'h0000_0001);
        SR_PRIV = 1'b1;
        step;
        MC_VALID = 1'b0;
        check({31'h0, EXC_ALLOW}, 32'h0000_0000);
        EXC_REQ_CFG = 1'b0;
        step;
        check({31'h0, EXC_ALLOW}, 32'h0000_0001);
        sr_op(1'b0, csx_pkg::SEL_CFG_MASK, 1'b1, 32'h0);
        check(rd, 32'h0000_0001);
        sr_op(1'b0, csx_pkg::SEL_CFG_MASK, 1'b0, 32'h0);
        check(rd, 32'h0000_0000);
        sr_op(1'b1, csx_pkg::SEL_CFG_MASK, 1'b1, 32'h0000_0000);
        sr_op(1'b1, csx_pkg::SEL_NMI_MASK, 1'b1, 32'h0000_0001);
        EXC_REQ_NUM = csx_pkg::EXC_NMI;
        step;
        check({31'h0, EXC_ALLOW}, 32'h0000_0001);
        EXC_REQ_NUM = csx_pkg::EXC_HARD_FAULT;
        step;
        check({31'h0, EXC_ALLOW}, 32'h0000_0000);
        exc_enter(csx_pkg::EXC_NMI);
        exc_ret(32'h0100_0000);
        sr_op(1'b0, csx_pkg::SEL_NMI_MASK, 1'b1, 32'h0);
        check(rd, 32'h0000_0001);
        exc_enter(csx_pkg::EXC_BUS_FAULT);
        exc_ret(32'h0100_0000);
        sr_op(1'b0, csx_pkg::SEL_NMI_MASK, 1'b1, 32'h0);
        check(rd, 32'h0000_0000);
        check({31'h0, EXC_ALLOW}, 32'h0000_0001);
        MC_VALID = 1'b1; MC_NMI_MASK = 1'b1;
        step;
        check({31'h0, EXC_ALLOW}, 32'h0000_0000);
        MC_DISABLE = 1'b0;
        step;
        MC_VALID = 1'b0;
        check({31'h0, EXC_ALLOW}, 32'h0000_0001);
    endtask : t_masks

    task t_resume;
        XFER_SUSPEND = 1'b1; XFER_NEXT_IDX = 4'h5;
        step;
        XFER_SUSPEND = 1'b0;
        check({27'h0, RESUME_VALID, RESUME_IDX}, 32'h0000_0015);
        check({16'h0, STACKED_PSR[15:12], 12'h0}, 32'h0000_5000);
        check({28'h0, STACKED_PSR[26:25], STACKED_PSR[11:10]}, 32'h0000_0000);
        XFER_DONE = 1'b1;
        step;
        XFER_DONE = 1'b0;
        check({31'h0, RESUME_VALID}, 32'h0000_0000);
        exc_ret(32'h0100_9000);
        check({27'h0, RESUME_VALID, RESUME_IDX}, 32'h0000_0019);
        XFER_DONE = 1'b1;
        step;
        XFER_DONE = 1'b0;
    endtask : t_resume

    task t_cond;
        COND_LOAD = 1'b1; COND_VALUE = 8'h34;
        step;
        COND_LOAD = 1'b0;
        check({27'h0, COND_ACTIVE, COND_CODE}, 32'h0000_0013);
        COND_ADVANCE = 1'b1;
        step;
        check({27'h0, COND_ACTIVE, COND_CODE}, 32'h0000_0012);
        step;
        COND_ADVANCE = 1'b0;
        check({31'h0, COND_ACTIVE}, 32'h0000_0000);
    endtask : t_cond

    task t_state_bit;
        EXEC_ATTEMPT = 1'b1;
        BRX_VALID = 1'b1; BRX_TARGET = 32'h0000_0200;
        step;
        check(INSTR_PTR, 32'h0000_0200);
        check({30'h0, STACKED_PSR[24], T_FAULT}, 32'h0000_0001);
        BRX_TARGET = 32'h0000_0301;
        step;
        BRX_VALID = 1'b0;
        check({30'h0, STACKED_PSR[24], T_FAULT}, 32'h0000_0002);
        EXEC_ATTEMPT = 1'b0;
    endtask : t_state_bit

    initial
    begin
        repeat (6) @(negedge CLK);
        RST = 1'b0;
        step;
        t_vector;
        t_flags;
        t_views;
        t_masks;
        t_resume;
        t_cond;
        t_state_bit;
        report_and_stop;
    end
endmodule : tb
